// >>> fpc_arr_model.sv
/* array page model for the flash controller bench.
   assumes a page is wanted only while arr_rd is high. */
`timescale 1ns/1ps
module fpc_arr_model (
    // fetch request
    input  wire logic         arr_rd,
    input  wire logic [11:0]  arr_page,
    // page data
    output logic      [255:0] arr_data
);
    // word i carries page and index; inverted outside a fetch so stale data cannot match
    always_comb begin
        for (int i = 0; i < 8; i++) begin
            arr_data[32*i+:32] = {arr_page, 4'(i), 16'h5aa5} ^ {32{!arr_rd}};
        end
    end
endmodule

// >>> fpc_ctrl.sv
/*
 * flash page read and program controller: cpu access sequencing,
 * two read page buffers, eight program page buffers, control register.
 * assumes the array returns a whole read page in the cycle ARR_RD is
 * high, and that the cpu waits for ACK or ERR before its next REQ.
 */
`timescale 1ns/1ps

module fpc_ctrl #(
    parameter int AW       = fpc_pkg::ARR_AW,
    parameter int NB       = fpc_pkg::NBLK,
    parameter int PPW      = fpc_pkg::PP_WORDS,
    parameter int RPW      = fpc_pkg::RP_WORDS,
    parameter int DISCH    = fpc_pkg::HV_DISCH_CYC
) (
    // clock and master reset
    input  wire logic                   CLK,
    input  wire logic                   NRST,
    // cpu request
    input  wire logic                   REQ,
    input  wire logic                   WE,
    input  wire logic                   REG_SEL,
    input  wire logic                   HALF,
    input  wire logic [AW-1:0]          ADDR,
    input  wire logic [31:0]            WDATA,
    // cpu answer
    output logic                        ACK,
    output logic                        ERR,
    output logic      [31:0]            RDATA,
    // operating modes
    input  wire logic                   STOP,
    input  wire logic                   DISABLE,
    input  wire logic                   SHADOW_SEL,
    // array read port
    output logic                        ARR_RD,
    output logic                        ARR_MARGIN,
    output logic      [AW-6:0]          ARR_PAGE,
    input  wire logic [RPW*32-1:0]      ARR_DATA,
    // program path to the array
    output logic      [AW-10:0]         PGM_OFS,
    input  wire logic [2:0]             PB_BLK,
    input  wire logic [3:0]             PB_WORD,
    output logic      [31:0]            PB_DATA,
    // high voltage
    input  wire logic                   HV_STATUS,
    output logic      [7:0]             HV_BLK_EN,
    output logic                        HV_DISCHARGE
);

    localparam int TW  = AW - fpc_pkg::RP_LSB;          // read page tag width
    localparam int OW  = AW - 3 - fpc_pkg::PP_LSB;      // program page offset width

    typedef struct packed {
        fpc_pkg::fpc_bus_e             st;
        logic [1:0]                    cnt;
        logic                          ack;
        logic                          err;
        logic [31:0]                   rdata;
        logic                          arr_rd;
        logic                          arr_marg;
        logic [TW-1:0]                 arr_page;
        logic [AW-1:0]                 pend;
        logic                          pend_half;
        logic [1:0]                    rv;
        logic [1:0][TW-1:0]            rtag;
        logic [1:0][RPW-1:0][31:0]     rbuf;
        logic [NB-1:0][PPW-1:0][31:0]  pbuf;     // one 64-byte page per block
        logic                          sequence_start_end_bit;
        logic                          high_voltage_enable_bit;
        logic                          erase;
        logic [7:0]                    block;
        logic [7:0]                    protect;
        logic                          pw_seen;
        logic                          ilk;
        logic                          pw_lock;
        logic [OW-1:0]                 ofs;
        logic                          h1;
        logic                          h2;
        logic                          h3;
        logic                          high_voltage_status_bit;
        logic                          sie_p;
        logic                          stop_p;
        logic                          dis_p;
        logic [31:0]                   pb_data;
    } fpc_state_s;

    fpc_state_s q, d;

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    // word or half-word lane, half-words land in the low bits
    function automatic logic [31:0] lane(input logic [31:0] w, input logic h, input logic a1);
        if (!h) begin
            lane = w;
        end else begin
            lane = {16'h0000, a1 ? w[31:16] : w[15:0]};
        end
    endfunction

    // once a programming write has been seen every access is pinned
    // to the latched page offset, whatever the cpu supplies
    function automatic logic [AW-1:0] remap(input logic [AW-1:0] a, input logic seen,
                                            input logic [OW-1:0] o);
        remap = a;
        if (seen) begin
            remap[AW-4:fpc_pkg::PP_LSB] = o;
        end
    endfunction

    // ------------------------------------------------------------
    // next state
    // ------------------------------------------------------------
    logic [AW-1:0] ea;
    logic          b;
    logic          pb;
    logic [2:0]    wblk;
    logic [3:0]    widx;
    logic [31:0]   ctl;

    always_comb begin
        d    = q;
        ea   = remap(ADDR, q.pw_seen, q.ofs);
        b    = ea[AW-1];
        pb   = q.pend[AW-1];
        wblk = ADDR[AW-1:AW-3];
        widx = ADDR[fpc_pkg::PP_LSB-1:fpc_pkg::WORD_LSB];
        ctl  = '0;
        ctl[fpc_pkg::F_BLOCK+:8]   = q.block;
        ctl[fpc_pkg::F_PROTECT+:8] = q.protect;
        ctl[fpc_pkg::F_ERASE]      = q.erase;
        ctl[fpc_pkg::F_SES]        = q.sequence_start_end_bit;
        ctl[fpc_pkg::F_EHV]        = q.high_voltage_enable_bit;
        ctl[fpc_pkg::F_HVS]        = q.high_voltage_status_bit;

        d.ack      = 1'b0;
        d.err      = 1'b0;
        d.arr_rd   = 1'b0;
        d.arr_marg = 1'b0;

        // status from the pump is asynchronous: three flops, taken when
        // the last two agree so a glitch never reaches the lockouts
        d.h1 = HV_STATUS;
        d.h2 = q.h1;
        d.h3 = q.h2;
        if (q.h2 == q.h3) begin
            d.high_voltage_status_bit = q.h3;
        end

        d.sie_p   = SHADOW_SEL;
        d.stop_p  = STOP;
        d.dis_p   = DISABLE;
        d.pb_data = q.pbuf[PB_BLK][PB_WORD];

        unique case (q.st)
            fpc_pkg::B_IDLE: begin
                if (REQ && REG_SEL) begin
                    if (ADDR[fpc_pkg::REG_IW+1:2] != fpc_pkg::CTL_IDX) begin
                        d.err = 1'b1;
                    end else begin
                        d.ack   = 1'b1;
                        d.rdata = ctl;
                        if (WE) begin
                            // masks and mode lock while a sequence runs
                            if (!q.sequence_start_end_bit) begin
                                d.block   = WDATA[fpc_pkg::F_BLOCK+:8];
                                d.protect = WDATA[fpc_pkg::F_PROTECT+:8];
                                d.erase   = WDATA[fpc_pkg::F_ERASE];
                            end
                            if (!q.high_voltage_enable_bit && !q.high_voltage_status_bit) begin
                                d.sequence_start_end_bit = WDATA[fpc_pkg::F_SES];
                            end
                            if (!WDATA[fpc_pkg::F_EHV]) begin
                                d.high_voltage_enable_bit = 1'b0;
                            end else if (q.sequence_start_end_bit && WDATA[fpc_pkg::F_SES] && !q.high_voltage_enable_bit &&
                                         (q.pw_seen || q.ilk)) begin
                                d.high_voltage_enable_bit     = 1'b1;
                                d.pw_lock = 1'b1;
                                d.rv      = '0;
                            end
                            if (q.sequence_start_end_bit && !d.sequence_start_end_bit) begin
                                d.pw_seen = 1'b0;
                                d.ilk     = 1'b0;
                                d.pw_lock = 1'b0;
                                d.rv      = '0;
                            end
                        end
                    end
                end else if (REQ && !STOP && !DISABLE) begin
                    if (q.high_voltage_enable_bit || q.high_voltage_status_bit) begin
                        d.err = 1'b1;
                    end else if (WE) begin
                        if (!q.sequence_start_end_bit) begin
                            d.err = 1'b1;
                        end else if (q.erase) begin
                            d.ilk = 1'b1;  // erase interlock write
                            d.ack = 1'b1;
                            d.rv  = '0;
                        end else if (q.pw_lock) begin
                            d.err = 1'b1;  // no refill after a pulse until resequenced
                        end else begin
                            if (!q.pw_seen) begin
                                d.ofs     = ADDR[AW-4:fpc_pkg::PP_LSB];
                                d.pw_seen = 1'b1;
                            end
                            // zeros in the buffer mark bits to program; the pump
                            // can only pull ones to zero
                            if (!HALF) begin
                                d.pbuf[wblk][widx] = WDATA;
                            end else if (ADDR[1]) begin
                                d.pbuf[wblk][widx][31:16] = WDATA[15:0];
                            end else begin
                                d.pbuf[wblk][widx][15:0] = WDATA[15:0];
                            end
                            d.ack = 1'b1;
                            d.rv  = '0;
                        end
                    end else if (q.rv[b] && q.rtag[b] == ea[AW-1:fpc_pkg::RP_LSB]) begin
                        d.ack   = 1'b1;
                        d.rdata = lane(q.rbuf[b][ea[4:2]], HALF, ea[1]);
                    end else begin
                        d.rv[b]     = 1'b0;
                        d.arr_rd    = 1'b1;
                        d.arr_marg  = q.pw_seen && !q.erase;
                        d.arr_page  = ea[AW-1:fpc_pkg::RP_LSB];
                        d.pend      = ea;
                        d.pend_half = HALF;
                        d.st        = fpc_pkg::B_FETCH;
                    end
                end
            end
            fpc_pkg::B_FETCH: begin
                d.rbuf[pb] = ARR_DATA;
                d.rtag[pb] = q.arr_page;
                d.rdata    = lane(ARR_DATA[q.pend[4:2]*32+:32], q.pend_half, q.pend[1]);
                if (q.arr_marg) begin
                    // margin data is status, so the page never turns valid
                    // and the next read margins again
                    for (int i = 0; i < RPW; i++) begin
                        d.pbuf[q.pend[AW-1:AW-3]][{q.pend[5], 3'(i)}] =
                            q.pbuf[q.pend[AW-1:AW-3]][{q.pend[5], 3'(i)}]
                            | ~ARR_DATA[i*32+:32];
                    end
                    d.cnt = fpc_pkg::MARG_LAST;
                    d.st  = fpc_pkg::B_MARG;
                end else begin
                    d.rv[pb] = 1'b1;
                    d.ack    = 1'b1;
                    d.st     = fpc_pkg::B_IDLE;
                end
            end
            fpc_pkg::B_MARG: begin
                if (q.cnt == 2'h0) begin
                    d.ack = 1'b1;
                    d.st  = fpc_pkg::B_IDLE;
                end else begin
                    d.cnt = q.cnt - 2'h1;
                end
            end
            default: begin
                d.st = fpc_pkg::B_IDLE;
            end
        endcase

        // mode changes make both read pages suspect
        if ((q.sie_p != SHADOW_SEL) || (q.stop_p && !STOP) || (q.dis_p && !DISABLE)) begin
            d.rv = '0;
        end

        // outside a sequence nothing may be programmed
        if (!d.sequence_start_end_bit) begin
            d.pbuf = '1;
        end

        // master reset wins over everything, mid-fetch included
        if (!NRST) begin
            d      = '0;
            d.pbuf = '1;
            d.st   = fpc_pkg::B_IDLE;
        end
    end

    always_ff @(posedge CLK) begin
        q <= d;
    end

    // ------------------------------------------------------------
    // high voltage gate
    // ------------------------------------------------------------
    // guarded blocks are masked before the pump ever sees them
    logic [7:0] hv_req;

    assign hv_req = q.high_voltage_enable_bit ? (q.block & ~q.protect) : 8'h00;

    fpc_hv_seq #(
        .DISCH_CYC (DISCH)
    ) u_hv (
        .clk       (CLK),
        .nrst      (NRST),
        .req       (hv_req),
        .blk_en    (HV_BLK_EN),
        .discharge (HV_DISCHARGE)
    );

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    assign ACK        = q.ack;
    assign ERR        = q.err;
    assign RDATA      = q.rdata;
    assign ARR_RD     = q.arr_rd;
    assign ARR_MARGIN = q.arr_marg;
    assign ARR_PAGE   = q.arr_page;
    assign PGM_OFS    = q.ofs;
    assign PB_DATA    = q.pb_data;

endmodule

// >>> fpc_ctrl_sva.sv
/* timing checks for the flash controller ports.
   assumes the master waits for each answer before its next request. */
`timescale 1ns/1ps
module fpc_ctrl_sva #(
    parameter int AW    = 17,
    parameter int DISCH = 1000
) (
    // clock, reset and request
    input wire logic          CLK,
    input wire logic          NRST,
    input wire logic          REQ,
    input wire logic          WE,
    input wire logic          REG_SEL,
    input wire logic [AW-1:0] ADDR,
    input wire logic          STOP,
    input wire logic          DISABLE,
    // answers and array side
    input wire logic          ACK,
    input wire logic          ERR,
    input wire logic          ARR_RD,
    input wire logic          ARR_MARGIN,
    input wire logic [7:0]    HV_BLK_EN,
    input wire logic          HV_DISCHARGE
);
    default clocking cb @(posedge CLK); endclocking
    default disable iff (!NRST);
    logic [15:0] dis_q = 16'h0000;
    // discharge length; not reset, since the ramp-down runs through reset
    always_ff @(posedge CLK) dis_q <= HV_DISCHARGE ? dis_q + 16'h0001 : 16'h0000;
    sequence arr_req;
        REQ && !REG_SEL && !STOP && !DISABLE;
    endsequence
    sequence marg_wait;
        !ACK ##1 !ACK ##1 ACK;
    endsequence
    reg_ack_a: assert property (REQ && REG_SEL && ADDR[5:2] == 4'h0 |=> ACK && !ERR)
        else $error("register access not acked in one clock");
    bad_reg_a: assert property (REQ && REG_SEL && ADDR[5:2] != 4'h0 |=> ERR && !ACK)
        else $error("unmapped register not errored");
    mode_silent_a: assert property (REQ && !REG_SEL && (STOP || DISABLE) |=> (!ACK && !ERR)[*3])
        else $error("array access answered in stop or disable");
    read_start_a: assert property (arr_req and !WE |=> ARR_RD != (ACK || ERR))
        else $error("array read neither answered nor fetched");
    write_ans_a: assert property (arr_req and WE |=> ACK != ERR && !ARR_RD)
        else $error("array write answer wrong");
    miss_ack_a: assert property (ARR_RD && !ARR_MARGIN |=> ACK && !ERR)
        else $error("page miss not answered in two clocks");
    margin_ack_a: assert property (ARR_RD && ARR_MARGIN |=> marg_wait)
        else $error("margin read timing wrong");
    reset_quiet_a: assert property (disable iff (1'b0) !NRST |=> !ACK && !ERR && !ARR_RD)
        else $error("activity during reset");
    dis_len_a: assert property ($fell(HV_DISCHARGE) |-> dis_q == 16'(DISCH) && HV_BLK_EN == 8'h00)
        else $error("discharge length wrong");
endmodule
bind fpc_ctrl fpc_ctrl_sva #(.AW(AW), .DISCH(DISCH)) u_sva (.CLK(CLK), .NRST(NRST), .REQ(REQ),
    .WE(WE), .REG_SEL(REG_SEL), .ADDR(ADDR), .STOP(STOP), .DISABLE(DISABLE), .ACK(ACK),
    .ERR(ERR), .ARR_RD(ARR_RD), .ARR_MARGIN(ARR_MARGIN), .HV_BLK_EN(HV_BLK_EN),
    .HV_DISCHARGE(HV_DISCHARGE));

// >>> fpc_ctrl_tb_top.sv
/* self-checking bench: cpu access tasks driving the controller.
   assumes the array model answers pages by index pattern. */
`timescale 1ns/1ps
module fpc_ctrl_tb_top;
    logic        clk = 1'b0, nrst = 1'b0, req = 1'b0, we = 1'b0, reg_sel = 1'b0;
    logic        stop = 1'b0, dis = 1'b0, shd = 1'b0, high_voltage_status_bit = 1'b0, hf = 1'b0, e;
    logic        ack, err, arr_rd, marg, hv_dis;
    logic [16:0] addr = '0;
    logic [31:0] wdata = '0, rdata, pb_data, rd;
    logic [11:0] page;
    logic [255:0] arr_data;
    logic [7:0]  ofs, hv_en;
    logic [2:0]  pb_blk = '0;
    logic [3:0]  pb_word = '0;
    int          failures = 0, checks_done = 0, cyc;
    always #5 clk = ~clk;
    fpc_ctrl #(.DISCH(4)) dut (.CLK(clk), .NRST(nrst), .REQ(req), .WE(we), .REG_SEL(reg_sel),
        .HALF(hf), .ADDR(addr), .WDATA(wdata), .ACK(ack), .ERR(err), .RDATA(rdata),
        .STOP(stop), .DISABLE(dis), .SHADOW_SEL(shd), .ARR_RD(arr_rd), .ARR_MARGIN(marg),
        .ARR_PAGE(page), .ARR_DATA(arr_data), .PGM_OFS(ofs), .PB_BLK(pb_blk),
        .PB_WORD(pb_word), .PB_DATA(pb_data), .HV_STATUS(high_voltage_status_bit), .HV_BLK_EN(hv_en),
        .HV_DISCHARGE(hv_dis));
    fpc_arr_model u_arr (.arr_rd(arr_rd), .arr_page(page), .arr_data(arr_data));
    task automatic stop_test();
        $display("checks %0d failures %0d", checks_done, failures);
        if (failures == 0 && checks_done > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            failures++;
            $display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    // one access; cyc is edges from taking edge to answer, 8 if none came (q: none wanted)
    task automatic acc(input logic w, r, input logic [16:0] a, input logic [31:0] d, input logic q);
        tick(1);
        req = 1'b1;
        we = w;
        reg_sel = r;
        addr = a;
        wdata = d;
        tick(1);
        req = 1'b0;
        cyc = 1;
        while (ack !== 1'b1 && err !== 1'b1 && cyc < 8) begin
            tick(1);
            cyc++;
        end
        e = err;
        rd = rdata;
        if (cyc == 8 && !q) begin
            failures++;
            $display("CHECK FAILED at %0t: no answer", $time);
            stop_test();
        end
    endtask
    initial begin
        tick(12);
        nrst = 1'b1;
        // ---------------- registers and plain reads ----------------
        acc(1, 1, 0, 32'h0000_0405, 0);
        chk(cyc, 1);
        acc(0, 1, 0, 0, 0);
        chk(rd, 32'h0000_0405);
        acc(0, 1, 17'h00004, 0, 0);
        chk(e, 1);
        acc(0, 0, 17'h00024, 0, 0);
        chk(cyc, 2);
        chk(rd, 32'h0011_5aa5);
        acc(0, 0, 17'h00028, 0, 0);
        chk(cyc, 1);
        chk(rd, 32'h0012_5aa5);
        shd = 1'b1;
        hf = 1'b1;
        acc(0, 0, 17'h0002a, 0, 0);
        chk(cyc, 2);
        chk(rd, 32'h0000_0012);
        hf = 1'b0;
        stop = 1'b1;
        acc(0, 0, 17'h00028, 0, 1);
        chk(cyc, 8);
        stop = 1'b0;
        acc(0, 0, 17'h00028, 0, 0);
        chk(cyc, 2);
        dis = 1'b1;
        acc(0, 0, 17'h00028, 0, 1);
        chk(cyc, 8);
        dis = 1'b0;
        acc(0, 0, 17'h00028, 0, 0);
        chk(cyc, 2);
        acc(1, 0, 17'h00028, 0, 0);
        chk(e, 1);
        // ---------------- program sequence, each page written once ----------------
        acc(1, 1, 0, 32'h0002_0405, 0);
        acc(1, 1, 0, 32'h0006_0405, 0);
        acc(0, 1, 0, 0, 0);
        chk(rd, 32'h0002_0405);
        acc(1, 0, 17'h004c4, 32'h0000_ffff, 0);
        chk(ofs, 8'h13);
        acc(1, 0, 17'h0d548, 32'h1234_abcd, 0);
        pb_blk = 3'd3;
        pb_word = 4'd2;
        tick(2);
        chk(pb_data, 32'h1234_abcd);
        pb_blk = 3'd0;
        pb_word = 4'd1;
        tick(2);
        chk(pb_data, 32'h0000_ffff);
        acc(0, 0, 17'h00004, 0, 0);
        chk(cyc, 4);
        chk(rd, 32'h0261_5aa5);
        tick(1);
        chk(pb_data, 32'hfd9e_ffff);
        acc(1, 1, 0, 32'h0006_0405, 0);
        tick(2);
        chk(hv_en, 8'h01);
        acc(0, 0, 17'h00004, 0, 0);
        chk(e, 1);
        // ---------------- reset with high voltage on ----------------
        nrst = 1'b0;
        tick(2);
        chk({hv_dis, hv_en}, 9'h101);
        nrst = 1'b1;
        acc(0, 1, 0, 0, 0);
        chk(rd, 0);
        pb_blk = 3'd3;
        pb_word = 4'd2;
        tick(2);
        chk(pb_data, 32'hffff_ffff);
        for (int i = 0; i < 20 && hv_dis; i++) tick(1);
        chk({hv_dis, hv_en}, 0);
        high_voltage_status_bit = 1'b1;
        tick(4);
        acc(0, 0, 17'h00024, 0, 0);
        chk(e, 1);
        stop_test();
    end
endmodule

// >>> fpc_hv_seq.sv
/*
 * high-voltage gate sequencer: passes the selected block mask to the
 * pump and ramps it down through a timed discharge, also when reset hits.
 * assumes a synchronous active-low reset shared with the controller.
 */
`timescale 1ns/1ps
module fpc_hv_seq #(
    parameter int DISCH_CYC = fpc_pkg::HV_DISCH_CYC,
    parameter int CW        = $clog2(DISCH_CYC + 1)
) (
    // clock and reset
    input  wire logic         clk,
    input  wire logic         nrst,
    // requested block mask
    input  wire logic [7:0]   req,
    // pump side
    output logic      [7:0]   blk_en,
    output logic              discharge
);

    typedef struct packed {
        fpc_pkg::fpc_hv_e st;
        logic [CW-1:0]    cnt;
        logic [7:0]       blk;
        logic             dis;
    } fpc_hv_s;

    fpc_hv_s q, d;

    localparam logic [CW-1:0] LAST = CW'(DISCH_CYC - 1);

    // ------------------------------------------------------------
    // next state
    // ------------------------------------------------------------
    // reset does not simply drop the pump: an active pump always
    // leaves through the discharge state
    always_comb begin
        d = q;
        unique case (q.st)
            fpc_pkg::HV_IDLE: begin
                d.blk = '0;
                d.dis = 1'b0;
                if (nrst && (|req)) begin
                    d.st  = fpc_pkg::HV_ON;
                    d.blk = req;
                end
            end
            fpc_pkg::HV_ON: begin
                if (!nrst || req == '0) begin
                    d.st  = fpc_pkg::HV_DIS;
                    d.cnt = LAST;
                    d.dis = 1'b1;
                end else begin
                    d.blk = req;
                end
            end
            fpc_pkg::HV_DIS: begin
                if (q.cnt == '0) begin
                    d.st  = fpc_pkg::HV_IDLE;
                    d.blk = '0;
                    d.dis = 1'b0;
                end else begin
                    d.cnt = q.cnt - 1'b1;
                end
            end
            default: begin
                d = '0;
            end
        endcase
    end

    always_ff @(posedge clk) begin
        q <= d;
    end

    assign blk_en    = q.blk;
    assign discharge = q.dis;

endmodule

// >>> fpc_pkg.sv
/*
 * shared constants for the flash page read and program controller:
 * control register layout, array address layout, sequencer states,
 * timing counts.
 * assumes a 100 MHz system clock and 32-bit cpu data.
 */
package fpc_pkg;

    // ------------------------------------------------------------
    // clock and timing
    // ------------------------------------------------------------
    localparam int CLK_NS       = 10;
    localparam int HV_DISCH_NS  = 10000;                 // safe high-voltage ramp-down
    localparam int HV_DISCH_CYC = (HV_DISCH_NS + CLK_NS - 1) / CLK_NS;
    localparam int MARG_EXTRA   = 2;                     // extra clocks of a margin read
    localparam logic [1:0] MARG_LAST = 2'(MARG_EXTRA - 1);

    // ------------------------------------------------------------
    // array geometry
    // ------------------------------------------------------------
    localparam int ARR_AW   = 17;                        // byte address width of the array
    localparam int NBLK     = 8;                         // array blocks, one program buffer each
    localparam int PP_WORDS = 16;                        // 64-byte program page
    localparam int RP_WORDS = 8;                         // 32-byte read page
    localparam int RP_LSB   = 5;                         // read page tag starts here
    localparam int PP_LSB   = 6;                         // program page offset starts here
    localparam int WORD_LSB = 2;

    // ------------------------------------------------------------
    // register space
    // ------------------------------------------------------------
    localparam int         REG_IW  = 4;
    localparam logic [3:0] CTL_IDX = 4'h0;               // the only implemented register
    localparam int F_BLOCK   = 0;                        // [7:0] block select mask
    localparam int F_PROTECT = 8;                        // [15:8] write guard mask
    localparam int F_ERASE   = 16;
    localparam int F_SES     = 17;                       // sequence start/end bit
    localparam int F_EHV     = 18;                       // high voltage enable bit
    localparam int F_HVS     = 19;                       // high voltage status bit, read only

    // ------------------------------------------------------------
    // state encodings
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        B_IDLE  = 2'b00,
        B_FETCH = 2'b01,
        B_MARG  = 2'b10
    } fpc_bus_e;

    typedef enum logic [1:0] {
        HV_IDLE = 2'b00,
        HV_ON   = 2'b01,
        HV_DIS  = 2'b10
    } fpc_hv_e;

endpackage
